// ===== hw/qpc_pkg.sv
// Shared constants and types for the four-port counter and mailbox control.
// Assumes nothing of its surroundings; every design file uses it.
package qpc_pkg;

  // ---------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------
  localparam int QPC_PORTS = 4;
  localparam int QPC_AW = 16;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] QPC_CNT_RST = 16'h0000;
  localparam logic [15:0] QPC_MASK_RST = 16'hFFFF;
  localparam logic [3:0] QPC_FLAG_EN_RST = 4'hF;

  // ---------------------------------------------------------------------
  // Mailboxes: port 0 owns the top word, each next port the word below.
  // ---------------------------------------------------------------------
  localparam logic [15:0] QPC_MBX_TOP = 16'hFFFF;

  function automatic logic [15:0] qpc_mbx_addr(input int unsigned idx);
    return QPC_MBX_TOP - idx[15:0];
  endfunction

  // ---------------------------------------------------------------------
  // APB register map (byte offsets) and field positions
  // ---------------------------------------------------------------------
  localparam logic [11:0] QPC_OFS_CTRL = 12'h000;
  localparam logic [11:0] QPC_OFS_STAT = 12'h004;
  localparam logic [11:0] QPC_OFS_CNT = 12'h010;
  localparam logic [11:0] QPC_OFS_MASK = 12'h020;
  localparam int QPC_CTRL_FLAG_EN_LSB = 0;
  localparam int QPC_STAT_MBX_LSB = 0;
  localparam int QPC_STAT_WRAP_LSB = 4;
  localparam int QPC_STAT_RB_LSB = 8;

  // ---------------------------------------------------------------------
  // Readback sequencer and source select
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    QPC_RB_IDLE = 2'b00,
    QPC_RB_NOP = 2'b01,
    QPC_RB_DRIVE = 2'b11
  } qpc_rb_t;

  typedef enum logic {
    QPC_SRC_CNT = 1'b0,
    QPC_SRC_MASK = 1'b1
  } qpc_src_t;

endpackage

// ===== hw/qpc_mbx_if.sv
// Access strobes from the port logic to the mailbox flags, and the flags back.
// Assumes all strobes are valid in the cycle before the edge that takes them.
`timescale 1ns/1ns

interface qpc_mbx_if;
  logic [qpc_pkg::QPC_PORTS-1:0] wr;
  logic [qpc_pkg::QPC_PORTS-1:0] rd;
  logic [qpc_pkg::QPC_AW-1:0] addr [qpc_pkg::QPC_PORTS];
  logic [qpc_pkg::QPC_PORTS-1:0] flag_n;

  modport ports (output wr, output rd, output addr, input flag_n);
  modport store (input wr, input rd, input addr, output flag_n);
endinterface

// ===== hw/qpc_step.sv
// Masked increment of one burst counter, with its wrap indication.
// Assumes the unmasked field is a contiguous run of low-order bits.
`timescale 1ns/1ns

module qpc_step (
  input wire logic [qpc_pkg::QPC_AW-1:0] count, // Present counter value.
  input wire logic [qpc_pkg::QPC_AW-1:0] mask, // Wrap mask, one marks a counting bit.
  output logic [qpc_pkg::QPC_AW-1:0] next_count, // Counter after one step.
  output logic wrap // High when the counting field returns to zero.
);
  import qpc_pkg::*;

  logic [QPC_AW-1:0] step;
  logic [QPC_AW-1:0] field_sum;

  // A cleared mask bit 0 freezes address bit 0, so the count moves by two.
  always_comb begin
    step = mask[0] ? 16'h0001 : 16'h0002;
    field_sum = ((count & mask) + step) & mask;
    next_count = (count & ~mask) | field_sum;
    wrap = (mask != 16'h0000) && (field_sum == 16'h0000);
  end
endmodule

// ===== hw/qpc_mailbox.sv
// Mailbox flags: one active-low flag per owning port.
// Assumes strobes and addresses of every port are synchronous to clk.
`timescale 1ns/1ns

module qpc_mailbox (
  input wire logic clk, // Port clock.
  input wire logic rst_n, // Asynchronous whole-device reset, active low.
  qpc_mbx_if.store mbx // Access strobes in, flags out.
);
  import qpc_pkg::*;

  logic [QPC_PORTS-1:0] flag_n;
  logic [QPC_PORTS-1:0] next_flag_n;
  logic [QPC_PORTS-1:0] set_hit;
  logic [QPC_PORTS-1:0] clr_hit;

  // A set in the same cycle as the owner's read wins, so no message is lost.
  always_comb begin
    for (int o = 0; o < QPC_PORTS; o++) begin
      set_hit[o] = 1'b0;
      for (int w = 0; w < QPC_PORTS; w++) begin
        if (w != o && mbx.wr[w] && mbx.addr[w] == qpc_mbx_addr(o)) begin
          set_hit[o] = 1'b1; // [R6] [R10]
        end
      end
      clr_hit[o] = mbx.rd[o] && (mbx.addr[o] == qpc_mbx_addr(o)); // [R7] [R9]
      next_flag_n[o] = set_hit[o] ? 1'b0 : (clr_hit[o] ? 1'b1 : flag_n[o]); // [R8]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_n <= 4'hF; // [R3]
    end else begin
      flag_n <= next_flag_n;
    end
  end

  assign mbx.flag_n = flag_n;
endmodule

// ===== hw/qpc_ctrl_top.sv
// Top of the four-port burst counter, wrap mask, readback and mailbox control.
// Assumes each port's host logic and the APB master are clocked by pclk.
`timescale 1ns/1ns

// Function
// [R1] A low device reset resets everything at once, independent of any clock; flag_en and read data here reset on presetn only.
// [R2] Reset clears every counter to zero and sets every wrap mask to ones.
// [R3] Reset raises mailbox and wrap flags and deselects registered controls.
// [R4] The host must reset the device after power-up before trusting state.
// [R5] The four top words are mailboxes, FFFF for port one downward.
// [R6] A write by a non-owner to a mailbox drives the owner's flag low.
// [R7] The owner reading its own mailbox returns its flag high.
// [R8] Flags set on the writer's edge and clear on the reader's edge.
// [R9] A non-owner read of a mailbox leaves its flag unchanged.
// [R10] Simultaneous writes to one mailbox still assert the owner's flag.
// [R11] A low counter load takes the port address into the counter.
// [R12] A low counter step advances the counter on every clock edge.
// [R13] The counter spans the masked range and wraps after its last address.
// [R14] A low counter clear zeroes only the counter, not the mask.
// [R15] Counter readback drives the counter value onto the address lines.
// [R16] Device reset beats clear; mask load beats counter load.
// [R17] Counter and mask operations ignore both chip enables.
// [R18] Readback inserts one idle cycle and floats data when the port is enabled.
// [R19] Counter readback wins over mask readback when both are requested.
// [R20] Readback requests are sampled on the owning port's clock.
// [R21] A low mask load takes the port address into the wrap mask.
// [R22] The wrap flag pulses low one cycle when the counting field wraps.
// [R23] Bits outside the mask keep their loaded value during steps.
// [R24] With every control high the counter holds, lowest priority.
// [R25] Each port owns its own counter, mask and flags.
module qpc_ctrl_top (
  input wire logic pclk, // Clock for APB and all ports.
  input wire logic presetn, // APB reset, asynchronous, active low.
  input wire logic device_reset_n, // Whole-device reset pin, asynchronous, active low.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped offsets.
  input wire logic [qpc_pkg::QPC_PORTS-1:0][qpc_pkg::QPC_AW-1:0] addr_in, // Port address lines.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] counter_load_n, // Load counter, low.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] counter_step_n, // Step counter, low.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] counter_clear_n, // Clear counter, low.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] mask_load_n, // Load wrap mask, low.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] counter_readback_n, // Read counter back, low.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] mask_readback_n, // Read mask back, low.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] chip_enable_low_active, // Enable, low.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] chip_enable_high_active, // Enable, high.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] write_n, // Port direction, low for write.
  output logic [qpc_pkg::QPC_PORTS-1:0][qpc_pkg::QPC_AW-1:0] addr_out, // Readback value.
  output logic [qpc_pkg::QPC_PORTS-1:0] addr_oe, // Drive address lines, high.
  output logic [qpc_pkg::QPC_PORTS-1:0] data_float, // Data lines forced off, high.
  output logic [qpc_pkg::QPC_PORTS-1:0] port_selected, // Registered chip enable.
  output logic [qpc_pkg::QPC_PORTS-1:0] port_writing, // Registered write access.
  output logic [qpc_pkg::QPC_PORTS-1:0] mailbox_flag_n, // Mailbox flags, low pending.
  output logic [qpc_pkg::QPC_PORTS-1:0] wrap_flag_n // Counter wrap flags, low pulse.
);
  import qpc_pkg::*;

  // -----------------------------------------------------------------------
  // Reset
  // -----------------------------------------------------------------------
  // Either reset clears port and mailbox state without a clock; APB registers need presetn.
  logic rst_n;

  assign rst_n = presetn & device_reset_n; // [R1]

  // -----------------------------------------------------------------------
  // Per-port results gathered for the register file and the outputs
  // -----------------------------------------------------------------------
  logic [QPC_AW-1:0] cnt_v [QPC_PORTS];
  logic [QPC_AW-1:0] mask_v [QPC_PORTS];
  logic [QPC_AW-1:0] rb_addr_v [QPC_PORTS];
  logic [QPC_AW-1:0] acc_addr_v [QPC_PORTS];
  logic rb_oe_v [QPC_PORTS];
  logic rb_busy_v [QPC_PORTS];
  logic dfloat_v [QPC_PORTS];
  logic sel_v [QPC_PORTS];
  logic wsel_v [QPC_PORTS];
  logic wrap_v [QPC_PORTS];
  logic acc_wr_v [QPC_PORTS];
  logic acc_rd_v [QPC_PORTS];

  qpc_mbx_if mbx ();

  // -----------------------------------------------------------------------
  // Port logic, one copy per port
  // -----------------------------------------------------------------------
  for (genvar p = 0; p < QPC_PORTS; p++) begin : g_port
    logic [QPC_AW-1:0] count;
    logic [QPC_AW-1:0] next_count;
    logic [QPC_AW-1:0] mask;
    logic [QPC_AW-1:0] next_mask;
    logic [QPC_AW-1:0] step_count;
    logic step_wrap;
    logic wrap_n;
    logic next_wrap_n;
    logic rb_req;
    qpc_rb_t rb_state;
    qpc_rb_t next_rb_state;
    qpc_src_t rb_src;
    qpc_src_t next_rb_src;
    logic [QPC_AW-1:0] rb_addr;
    logic [QPC_AW-1:0] next_rb_addr;
    logic rb_oe;
    logic next_rb_oe;
    logic ce;
    logic acc;
    logic sel;
    logic next_sel;
    logic wsel;
    logic next_wsel;
    logic dfloat;
    logic next_dfloat;

    qpc_step u_step (
      .count(count),
      .mask(mask),
      .next_count(step_count),
      .wrap(step_wrap)
    );

    // Counter and mask controls in strict priority; chip enables take no part.
    always_comb begin
      next_count = count; // [R24]
      next_mask = mask;
      next_wrap_n = 1'b1;
      rb_req = 1'b0;
      if (!counter_clear_n[p]) begin
        next_count = QPC_CNT_RST; // [R14] [R16] [R17]
      end else if (!mask_load_n[p]) begin
        next_mask = addr_in[p]; // [R21] [R16]
      end else if (!counter_load_n[p]) begin
        next_count = addr_in[p]; // [R11]
      end else if (!counter_step_n[p]) begin
        next_count = step_count; // [R12] [R13] [R23]
        next_wrap_n = ~step_wrap; // [R22]
      end else if (!counter_readback_n[p] || !mask_readback_n[p]) begin
        rb_req = 1'b1; // [R20]
      end
    end

    always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
        count <= QPC_CNT_RST; // [R2]
        mask <= QPC_MASK_RST; // [R2]
        wrap_n <= 1'b1; // [R3]
      end else begin
        count <= next_count; // [R25]
        mask <= next_mask;
        wrap_n <= next_wrap_n;
      end
    end

    // Readback: the request edge is followed by one idle cycle, and the
    // value appears after the edge that ends it. A request held beyond that
    // keeps the lines driven and refreshed without another idle cycle.
    always_comb begin
      next_rb_state = rb_state;
      next_rb_src = rb_src;
      next_rb_addr = rb_addr;
      next_rb_oe = 1'b0;
      case (rb_state)
        QPC_RB_IDLE: begin
          if (rb_req) begin
            next_rb_state = QPC_RB_NOP; // [R18]
            next_rb_src = counter_readback_n[p] ? QPC_SRC_MASK : QPC_SRC_CNT; // [R19]
          end
        end
        QPC_RB_NOP: begin
          next_rb_state = QPC_RB_DRIVE;
          next_rb_addr = (rb_src == QPC_SRC_CNT) ? count : mask; // [R15] [R18]
          next_rb_oe = 1'b1;
        end
        QPC_RB_DRIVE: begin
          if (rb_req) begin
            next_rb_src = counter_readback_n[p] ? QPC_SRC_MASK : QPC_SRC_CNT; // [R19]
            next_rb_addr = counter_readback_n[p] ? mask : count; // [R15]
            next_rb_oe = 1'b1;
          end else begin
            next_rb_state = QPC_RB_IDLE;
          end
        end
        default: begin
          next_rb_state = QPC_RB_IDLE;
        end
      endcase
    end

    always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
        rb_state <= QPC_RB_IDLE;
        rb_src <= QPC_SRC_CNT;
        rb_addr <= QPC_CNT_RST;
        rb_oe <= 1'b0;
      end else begin
        rb_state <= next_rb_state;
        rb_src <= next_rb_src;
        rb_addr <= next_rb_addr;
        rb_oe <= next_rb_oe;
      end
    end

    // Memory access and registered enables. No access is made while a
    // readback is asked for or running, since the address lines are busy.
    always_comb begin
      ce = !chip_enable_low_active[p] && chip_enable_high_active[p];
      acc = ce && (rb_state == QPC_RB_IDLE) && !rb_req;
      next_sel = ce;
      next_wsel = acc && !write_n[p];
      next_dfloat = ce && (next_rb_state != QPC_RB_IDLE); // [R18]
    end

    always_ff @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
        sel <= 1'b0; // [R3]
        wsel <= 1'b0; // [R3]
        dfloat <= 1'b0;
      end else begin
        sel <= next_sel;
        wsel <= next_wsel;
        dfloat <= next_dfloat;
      end
    end

    // The access address is the one latched at this edge, so a mailbox
    // flag follows the same edge as the access that moves it.
    assign acc_wr_v[p] = acc && !write_n[p]; // [R8]
    assign acc_rd_v[p] = acc && write_n[p];
    assign acc_addr_v[p] = next_count; // [R5]
    assign cnt_v[p] = count;
    assign mask_v[p] = mask;
    assign rb_addr_v[p] = rb_addr;
    assign rb_oe_v[p] = rb_oe;
    assign rb_busy_v[p] = (rb_state != QPC_RB_IDLE);
    assign dfloat_v[p] = dfloat;
    assign sel_v[p] = sel;
    assign wsel_v[p] = wsel;
    assign wrap_v[p] = wrap_n;
  end

  // -----------------------------------------------------------------------
  // Mailbox flags
  // -----------------------------------------------------------------------
  qpc_mailbox u_mailbox (
    .clk(pclk),
    .rst_n(rst_n),
    .mbx(mbx)
  );

  // -----------------------------------------------------------------------
  // APB register file
  // -----------------------------------------------------------------------
  logic [QPC_PORTS-1:0] flag_en;
  logic [QPC_PORTS-1:0] next_flag_en;
  logic [31:0] prdata_q;
  logic [31:0] next_prdata;
  logic [31:0] rd_word;
  logic mapped;

  // Unmapped offsets read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped = 1'b0;
    case (paddr)
      QPC_OFS_CTRL: begin
        mapped = 1'b1;
        rd_word[QPC_CTRL_FLAG_EN_LSB +: QPC_PORTS] = flag_en;
      end
      QPC_OFS_STAT: begin
        mapped = 1'b1;
        for (int i = 0; i < QPC_PORTS; i++) begin
          rd_word[QPC_STAT_MBX_LSB + i] = mbx.flag_n[i];
          rd_word[QPC_STAT_WRAP_LSB + i] = wrap_v[i];
          rd_word[QPC_STAT_RB_LSB + i] = rb_busy_v[i];
        end
      end
      default: begin
        for (int i = 0; i < QPC_PORTS; i++) begin
          if (paddr == QPC_OFS_CNT + 12'(4 * i)) begin
            mapped = 1'b1;
            rd_word[QPC_AW-1:0] = cnt_v[i];
          end
          if (paddr == QPC_OFS_MASK + 12'(4 * i)) begin
            mapped = 1'b1;
            rd_word[QPC_AW-1:0] = mask_v[i];
          end
        end
      end
    endcase
  end

  // Read data is captured in the setup phase, so the slave never waits.
  always_comb begin
    next_flag_en = flag_en;
    next_prdata = prdata_q;
    if (psel && !penable && !pwrite) begin
      next_prdata = rd_word;
    end
    if (psel && penable && pwrite && paddr == QPC_OFS_CTRL && pstrb[0]) begin
      next_flag_en = pwdata[QPC_CTRL_FLAG_EN_LSB +: QPC_PORTS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_en <= QPC_FLAG_EN_RST;
      prdata_q <= 32'h0000_0000;
    end else begin
      flag_en <= next_flag_en;
      prdata_q <= next_prdata;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // -----------------------------------------------------------------------
  // Output and interface packing
  // -----------------------------------------------------------------------
  // A disabled mailbox flag output reads high; the
  // flag itself keeps running so software can still see it in the status.
  always_comb begin
    for (int i = 0; i < QPC_PORTS; i++) begin
      mbx.wr[i] = acc_wr_v[i];
      mbx.rd[i] = acc_rd_v[i];
      mbx.addr[i] = acc_addr_v[i];
      addr_out[i] = rb_addr_v[i];
      addr_oe[i] = rb_oe_v[i];
      data_float[i] = dfloat_v[i];
      port_selected[i] = sel_v[i];
      port_writing[i] = wsel_v[i];
      wrap_flag_n[i] = wrap_v[i];
      mailbox_flag_n[i] = mbx.flag_n[i] | ~flag_en[i];
    end
  end

endmodule

// ===== test/qpc_ctrl_chk.sv
// Assertions on the port-side outputs of qpc_ctrl_top.
// Assumes one clock, pclk, and the two active-low resets of the top.
`timescale 1ns/1ns

module qpc_ctrl_chk (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Bus reset.
  input wire logic device_reset_n, // Device reset.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] counter_load_n, // Load.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] counter_step_n, // Step.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] counter_clear_n, // Clear.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] mask_load_n, // Mask load.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] counter_readback_n, // Count readback.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] mask_readback_n, // Mask readback.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] chip_enable_low_active, // Enable, low.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] chip_enable_high_active, // Enable, high.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] addr_oe, // Address drive.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] data_float, // Data off.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] port_selected, // Enable seen.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] port_writing, // Write seen.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] mailbox_flag_n, // Mailbox flags.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] wrap_flag_n // Wrap flags.
);
  import qpc_pkg::*;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!(presetn && device_reset_n));

  // ----------------------------------------
  // Per-port relations
  // ----------------------------------------
  for (genvar i = 0; i < QPC_PORTS; i++) begin : g_port
    wrap_cause_a:
      assert property (!wrap_flag_n[i] |-> $past(!counter_step_n[i] && counter_clear_n[i]
        && mask_load_n[i] && counter_load_n[i])) else $error("wrap flag without a step");
    wrap_pulse_a:
      assert property ($fell(wrap_flag_n[i]) |=> wrap_flag_n[i])
        else $error("wrap flag longer than one cycle");
    rb_idle_a:
      assert property ($fell(counter_readback_n[i] & mask_readback_n[i]) && !addr_oe[i]
        && (counter_clear_n[i] & mask_load_n[i] & counter_load_n[i] & counter_step_n[i])
        |=> !addr_oe[i] ##1 addr_oe[i]) else $error("readback idle cycle wrong");
    rb_cause_a:
      assert property ($rose(addr_oe[i]) |->
        $past(!(counter_readback_n[i] && mask_readback_n[i]), 2))
        else $error("address drive without readback");
    rb_release_a:
      assert property (addr_oe[i] && counter_readback_n[i] && mask_readback_n[i] |=>
        !addr_oe[i]) else $error("address drive kept after release");
    float_cause_a:
      assert property ($rose(data_float[i]) |-> $past(!chip_enable_low_active[i]
        && chip_enable_high_active[i] && !(counter_readback_n[i] && mask_readback_n[i])))
        else $error("data float without enabled readback");
    mbx_set_a:
      assert property ($fell(mailbox_flag_n[i]) |-> (port_writing & ~(4'h1 << i)) != 4'h0)
        else $error("mailbox flag set without a foreign write");
    mbx_clear_a:
      assert property ($rose(mailbox_flag_n[i]) |-> port_selected[i] && !port_writing[i])
        else $error("mailbox flag cleared without owner read");
  end
endmodule

bind qpc_ctrl_top qpc_ctrl_chk qpc_ctrl_chk_inst (.*);

// ===== test/qpc_host_model.sv
// Host model for the four ports: controls, enables and address lines.
// Assumes the bench calls op() at most once at a time per port.
`timescale 1ns/1ns

module qpc_host_model (
  input wire logic pclk, // Port clock.
  input wire logic [qpc_pkg::QPC_PORTS-1:0][qpc_pkg::QPC_AW-1:0] addr_out, // Device value.
  input wire logic [qpc_pkg::QPC_PORTS-1:0] addr_oe, // Device drives lines.
  output logic [qpc_pkg::QPC_PORTS-1:0][qpc_pkg::QPC_AW-1:0] addr_in, // Line level.
  output logic [5:0][qpc_pkg::QPC_PORTS-1:0] ctl_n, // Controls, low active.
  output logic [qpc_pkg::QPC_PORTS-1:0] ce_n, // Enable, low.
  output logic [qpc_pkg::QPC_PORTS-1:0] ce, // Enable, high.
  output logic [qpc_pkg::QPC_PORTS-1:0] write_n // Write, low.
);
  import qpc_pkg::*;
  logic [QPC_PORTS-1:0][QPC_AW-1:0] hold = '0;
  logic [QPC_PORTS-1:0] drv = '0;

  initial begin
    ctl_n = '1;
    ce_n = '1;
    ce = '0;
    write_n = '1;
  end

  // A released line shows the inverse of its last value.
  always_comb begin
    for (int p = 0; p < QPC_PORTS; p++) begin
      addr_in[p] = addr_oe[p] ? addr_out[p] : (drv[p] ? hold[p] : ~hold[p]);
    end
  end

  // Control bits 0 to 5 are clear, mask load, load, step, count and mask readback.
  // Bit 6 keeps the port deselected. Everything is released at the n-th edge.
  task automatic op(input int p, input logic [6:0] c, input logic [15:0] a,
                    input logic wr, input int n);
    @(posedge pclk);
    for (int k = 0; k < 6; k++) ctl_n[k][p] <= !c[k];
    hold[p] <= a;
    drv[p] <= 1'b1;
    ce_n[p] <= c[6];
    ce[p] <= !c[6];
    write_n[p] <= !wr;
    repeat (n) @(posedge pclk);
    for (int k = 0; k < 6; k++) ctl_n[k][p] <= 1'b1;
    drv[p] <= 1'b0;
    ce_n[p] <= 1'b1;
    ce[p] <= 1'b0;
    write_n[p] <= 1'b1;
  endtask
endmodule

// ===== test/qpc_ctrl_top_tb.sv
// Bench for qpc_ctrl_top: APB register reads and host port operations.
// Assumes the host model drives every port input and APB shares pclk.
`timescale 1ns/1ns

module qpc_ctrl_top_tb;
  import qpc_pkg::*;
  logic pclk = 1'b0;
  logic presetn;
  logic device_reset_n;
  logic [11:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [QPC_PORTS-1:0][QPC_AW-1:0] addr_in, addr_out;
  logic [5:0][QPC_PORTS-1:0] ctl_n;
  logic [QPC_PORTS-1:0] ce_n, ce, write_n, addr_oe, data_float, mbx_n, wrap_n;
  logic [15:0] mb;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_wrap = 0;
  int w0;

  qpc_ctrl_top qpc_ctrl_top_inst (.*, .pstrb(4'hF),
    .counter_load_n(ctl_n[2]), .counter_step_n(ctl_n[3]), .counter_clear_n(ctl_n[0]),
    .mask_load_n(ctl_n[1]), .counter_readback_n(ctl_n[4]), .mask_readback_n(ctl_n[5]),
    .chip_enable_low_active(ce_n), .chip_enable_high_active(ce),
    .port_selected(), .port_writing(), .mailbox_flag_n(mbx_n), .wrap_flag_n(wrap_n));
  qpc_host_model qpc_host_model_inst (.*);

  initial begin
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    n_wrap <= n_wrap + $countones(~wrap_n);
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  function automatic logic [11:0] ofs(input logic [11:0] base, input int i);
    return base + 12'(4 * i);
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic op(input int p, input logic [6:0] c, input logic [15:0] a,
                    input logic wr, input int n);
    qpc_host_model_inst.op(p, c, a, wr, n);
  endtask

  task automatic rb(input int p, input logic [6:0] c, input logic [15:0] exp);
    op(p, c, 16'h0, 1'b0, 1);
    #1 chk("data float", 32'(data_float[p]), 32'(!c[6]));
    chk("idle cycle", 32'(addr_oe[p]), 32'h0);
    @(posedge pclk);
    #1 chk("readback drive", 32'(addr_oe[p]), 32'h1);
    chk("readback value", 32'(addr_out[p]), 32'(exp));
    @(posedge pclk);
    #1 chk("readback release", 32'(addr_oe[p]), 32'h0);
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Under two hundred cycles are needed; this allows five thousand.
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    device_reset_n = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    device_reset_n <= 1'b1;
    for (int i = 0; i < QPC_PORTS; i++) begin
      rchk("count", ofs(QPC_OFS_CNT, i), 32'h0);
      rchk("mask", ofs(QPC_OFS_MASK, i), 32'hFFFF);
    end
    rchk("status", QPC_OFS_STAT, 32'hFF);
    apb(1'b1, QPC_OFS_CNT, 32'h1234);
    rchk("read-only count", QPC_OFS_CNT, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", 32'(err), 32'h1);
    for (int i = 0; i < QPC_PORTS; i++) begin
      op(i, 7'h44, 16'h1238 + 16'(i), 1'b0, 1);
      rchk("load", ofs(QPC_OFS_CNT, i), 32'h1238 + i);
    end
    op(1, 7'h06, 16'h003F, 1'b0, 1);
    rchk("mask over load", ofs(QPC_OFS_MASK, 1), 32'h3F);
    rchk("load ignored", ofs(QPC_OFS_CNT, 1), 32'h1239);
    op(0, 7'h03, 16'h00F0, 1'b0, 1);
    rchk("clear", ofs(QPC_OFS_CNT, 0), 32'h0);
    rchk("mask kept", ofs(QPC_OFS_MASK, 0), 32'hFFFF);
    rchk("other port", ofs(QPC_OFS_CNT, 2), 32'h123A);
    w0 = n_wrap;
    op(1, 7'h08, 16'h0, 1'b0, 10);
    rchk("masked wrap", ofs(QPC_OFS_CNT, 1), 32'h1203);
    op(2, 7'h44, 16'hFFFE, 1'b0, 1);
    op(2, 7'h48, 16'h0, 1'b0, 3);
    rchk("full wrap", ofs(QPC_OFS_CNT, 2), 32'h1);
    chk("wrap pulses", 32'(n_wrap - w0), 32'h2);
    op(3, 7'h02, 16'h003E, 1'b0, 1);
    op(3, 7'h04, 16'h0005, 1'b0, 1);
    op(3, 7'h08, 16'h0, 1'b0, 3);
    rchk("step by two", ofs(QPC_OFS_CNT, 3), 32'hB);
    rb(1, 7'h30, 16'h1203);
    rb(1, 7'h20, 16'h003F);
    rb(3, 7'h50, 16'h000B);
    for (int o = 0; o < QPC_PORTS; o++) begin
      mb = 16'hFFFF - 16'(o);
      op((o + 1) % QPC_PORTS, 7'h04, mb, 1'b1, 1);
      #1 chk("mailbox set", 32'(mbx_n[o]), 32'h0);
      op((o + 2) % QPC_PORTS, 7'h04, mb, 1'b0, 1);
      #1 chk("foreign read", 32'(mbx_n[o]), 32'h0);
      op(o, 7'h04, mb, 1'b0, 1);
      #1 chk("owner read", 32'(mbx_n[o]), 32'h1);
    end
    fork
      op(0, 7'h04, 16'hFFFE, 1'b1, 1);
      op(2, 7'h04, 16'hFFFE, 1'b1, 1);
    join
    #1 chk("double write", 32'(mbx_n[1]), 32'h0);
    // Dropped between edges: the flags must follow without a clock.
    device_reset_n = 1'b0;
    #1 chk("async reset", 32'(mbx_n), 32'hF);
    @(posedge pclk);
    device_reset_n <= 1'b1;
    rchk("reset count", ofs(QPC_OFS_CNT, 1), 32'h0);
    rchk("reset mask", ofs(QPC_OFS_MASK, 1), 32'hFFFF);
    close_out();
  end
endmodule
